// ==== rtl/gpio_cd_pkg.sv ====
package gpio_cd_pkg;
  // Register byte offsets on the APB window
  localparam logic [11:0] OFF_C_PIN = 12'h000;
  localparam logic [11:0] OFF_C_LATCH = 12'h004;
  localparam logic [11:0] OFF_C_DIR = 12'h008;
  localparam logic [11:0] OFF_D_PIN = 12'h00c;
  localparam logic [11:0] OFF_D_LATCH = 12'h010;
  localparam logic [11:0] OFF_D_DIR = 12'h014;
  localparam logic [11:0] OFF_OD_FIRST = 12'h018;
  localparam logic [11:0] OFF_OD_THIRD = 12'h01c;
  localparam logic [11:0] OFF_PAD_CFG = 12'h020;
  localparam logic [11:0] OFF_MEM_CTRL = 12'h024;
  localparam logic [11:0] OFF_E_DIR = 12'h028;
  // Reset values
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_OD = 8'h00;
  localparam logic [7:0] RST_PAD_CFG = 8'h80;
  localparam logic [7:0] RST_MEM_CTRL = 8'h00;
  localparam logic [7:0] RST_E_DIR = 8'hff;
  // Writable bits of the partly implemented registers
  localparam logic [7:0] MASK_OD_FIRST = 8'he1;
  localparam logic [7:0] MASK_OD_THIRD = 8'hc1;
  localparam logic [7:0] MASK_PAD_CFG = 8'he6;
  localparam logic [7:0] MASK_MEM_CTRL = 8'h80;
  // Field positions
  localparam int BIT_SSP1_OD = 7;
  localparam int BIT_CCP2_OD = 6;
  localparam int BIT_CCP1_OD = 5;
  localparam int BIT_SSP2_OD = 0;
  localparam int BIT_U1_OD = 6;
  localparam int BIT_PULLUP_DIS = 7;
  localparam int BIT_EXT_BUS_DIS = 7;
  localparam int BIT_PSP_EN = 4;
  // Port C pin roles
  localparam int PIN_SEC_CLK = 0;
  localparam int PIN_CCP2 = 1;
  localparam int PIN_CCP1 = 2;
  // Port C pins grouped by the open-drain bit that governs them
  localparam logic [7:0] C_SSP1_PINS = 8'h38;
  localparam logic [7:0] C_U1_PINS = 8'hc0;
  // Port D serial pins
  localparam logic [7:0] D_SSP2_PINS = 8'h70;
endpackage

// ==== rtl/gpio_cd.sv ====
`timescale 1ns/1ps
// How it works
// - Two 8-bit ports, pin, latch, direction registers
// - Direction 0 drives latch, 1 is input
// - Reset leaves port C pins digital inputs; port D goes to the external bus
// - Peripherals may force pin direction
// - Direction read returns stored software value
// - Active peripheral output replaces latch data
// - Overridden pins ignore their direction bit
// - Peripheral pins go open-drain when bit set
// - Port D serial pins open-drain on bit 0
// - Compare unit two on C1 when select high
// - PWM outputs may float during shutdown
// - C0 clock input only with oscillator off
// - Pad config bit 7 disables D pull-ups
// - Pull-up off on any output pin
// - Reset disables port D pull-ups
// - External bus owns port D until disabled
// - Port E direction bit 4 selects slave port
// - Slave port only in microcontroller mode
module gpio_cd
  import gpio_cd_pkg::*;
#(
  parameter int PORT_WIDTH = 8, // Pins per port
  parameter bit WIDE_PACKAGE = 1'b1 // External bus bonded out
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // Port C pads
  input wire logic [PORT_WIDTH-1:0] C_PAD_IN,
  output logic [PORT_WIDTH-1:0] C_PAD_OUT,
  output logic [PORT_WIDTH-1:0] C_PAD_OE,
  // Port D pads
  input wire logic [PORT_WIDTH-1:0] D_PAD_IN,
  output logic [PORT_WIDTH-1:0] D_PAD_OUT,
  output logic [PORT_WIDTH-1:0] D_PAD_OE,
  output logic [PORT_WIDTH-1:0] D_PULLUP_EN,
  output logic D_TTL_INPUT,
  // Synchronised pin levels for the peripherals
  output logic [PORT_WIDTH-1:0] C_PIN_SYNC,
  output logic [PORT_WIDTH-1:0] D_PIN_SYNC,
  // Port C peripheral requests
  input wire logic [PORT_WIDTH-1:0] C_PERIPH_DATA_EN,
  input wire logic [PORT_WIDTH-1:0] C_PERIPH_DATA,
  input wire logic [PORT_WIDTH-1:0] C_PERIPH_DIR_OVR,
  input wire logic [PORT_WIDTH-1:0] C_PERIPH_DRIVE,
  input wire logic [PORT_WIDTH-1:0] C_PWM_FLOAT,
  // Port D peripheral requests
  input wire logic [PORT_WIDTH-1:0] D_PERIPH_DATA_EN,
  input wire logic [PORT_WIDTH-1:0] D_PERIPH_DATA,
  input wire logic [PORT_WIDTH-1:0] D_PERIPH_DIR_OVR,
  input wire logic [PORT_WIDTH-1:0] D_PERIPH_DRIVE,
  // External memory bus on port D
  input wire logic [PORT_WIDTH-1:0] EXT_BUS_DATA,
  input wire logic EXT_BUS_DRIVE,
  output logic EXT_BUS_OWNS_D,
  // Parallel slave port on port D
  input wire logic [PORT_WIDTH-1:0] PSP_DATA,
  input wire logic PSP_DRIVE,
  output logic PSP_ACTIVE,
  // Device mode and clock options
  input wire logic MCU_MODE,
  input wire logic COMPARE_TWO_PIN_SELECT,
  input wire logic SEC_OSC_ENABLE,
  output logic SEC_CLOCK_IN
);

  // Software registers
  logic [PORT_WIDTH-1:0] c_latch_reg;
  logic [PORT_WIDTH-1:0] c_dir_reg;
  logic [PORT_WIDTH-1:0] d_latch_reg;
  logic [PORT_WIDTH-1:0] d_dir_reg;
  logic [7:0] od_first_reg;
  logic [7:0] od_third_reg;
  logic [7:0] pad_cfg_reg;
  logic [7:0] mem_ctrl_reg;
  logic [7:0] e_dir_reg;

  // Synchroniser stages
  logic [PORT_WIDTH-1:0] c_meta_reg;
  logic [PORT_WIDTH-1:0] c_sync_reg;
  logic [PORT_WIDTH-1:0] d_meta_reg;
  logic [PORT_WIDTH-1:0] d_sync_reg;

  // Bus response flops
  logic ready_reg;
  logic [31:0] rdata_reg;
  logic err_reg;

  // Pad drive, registered so outputs come from flops
  logic [PORT_WIDTH-1:0] c_out_reg;
  logic [PORT_WIDTH-1:0] c_oe_reg;
  logic [PORT_WIDTH-1:0] d_out_reg;
  logic [PORT_WIDTH-1:0] d_oe_reg;
  logic [PORT_WIDTH-1:0] d_pull_reg;
  logic bus_own_reg;
  logic psp_reg;
  logic sec_clk_reg;

  // Combinational pin results
  logic [PORT_WIDTH-1:0] c_out_next;
  logic [PORT_WIDTH-1:0] c_oe_next;
  logic [PORT_WIDTH-1:0] d_out_next;
  logic [PORT_WIDTH-1:0] d_oe_next;
  logic [PORT_WIDTH-1:0] c_od_class;
  logic [PORT_WIDTH-1:0] d_od_class;

  // Decoded bus events
  logic setup_phase;
  logic wr_en;
  logic ext_bus_on;
  logic psp_on;
  logic [7:0] wbyte;
  logic [31:0] rdata_next;
  logic err_next;

  // A request is seen in its setup cycle; the write lands at the access edge
  assign setup_phase = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE & ready_reg & PSTRB[0];
  assign wbyte = PWDATA[7:0];

  // Bus takes port D while enabled; slave port only in controller mode
  assign ext_bus_on = WIDE_PACKAGE & ~mem_ctrl_reg[BIT_EXT_BUS_DIS];
  assign psp_on = e_dir_reg[BIT_PSP_EN] & MCU_MODE & ~ext_bus_on;

  // Two-stage pin synchronisers; only the second stage is ever read
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      c_meta_reg <= '0;
      c_sync_reg <= '0;
      d_meta_reg <= '0;
      d_sync_reg <= '0;
    end else begin
      c_meta_reg <= C_PAD_IN;
      c_sync_reg <= c_meta_reg;
      d_meta_reg <= D_PAD_IN;
      d_sync_reg <= d_meta_reg;
    end
  end

  // Port C latch; a write to the pin register lands in the latch too
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      c_latch_reg <= PORT_WIDTH'(RST_LATCH);
    end else if (wr_en && (PADDR == OFF_C_PIN || PADDR == OFF_C_LATCH)) begin
      c_latch_reg <= PORT_WIDTH'(wbyte);
    end
  end

  // Port D latch
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      d_latch_reg <= PORT_WIDTH'(RST_LATCH);
    end else if (wr_en && (PADDR == OFF_D_PIN || PADDR == OFF_D_LATCH)) begin
      d_latch_reg <= PORT_WIDTH'(wbyte);
    end
  end

  // Direction registers; all ones at reset so every pin not owned by the external bus is an input
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      c_dir_reg <= PORT_WIDTH'(RST_DIR);
      d_dir_reg <= PORT_WIDTH'(RST_DIR);
    end else if (wr_en) begin
      if (PADDR == OFF_C_DIR) begin
        c_dir_reg <= PORT_WIDTH'(wbyte);
      end
      if (PADDR == OFF_D_DIR) begin
        d_dir_reg <= PORT_WIDTH'(wbyte);
      end
    end
  end

  // Open-drain controls; unimplemented bits stay zero
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      od_first_reg <= RST_OD;
      od_third_reg <= RST_OD;
    end else if (wr_en) begin
      if (PADDR == OFF_OD_FIRST) begin
        od_first_reg <= wbyte & MASK_OD_FIRST;
      end
      if (PADDR == OFF_OD_THIRD) begin
        od_third_reg <= wbyte & MASK_OD_THIRD;
      end
    end
  end

  // Pad configuration; pull-ups come out of reset disabled
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pad_cfg_reg <= RST_PAD_CFG;
    end else if (wr_en && PADDR == OFF_PAD_CFG) begin
      pad_cfg_reg <= wbyte & MASK_PAD_CFG;
    end
  end

  // Memory control and port E direction, held here for the port D muxes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mem_ctrl_reg <= RST_MEM_CTRL;
      e_dir_reg <= RST_E_DIR;
    end else if (wr_en) begin
      if (PADDR == OFF_MEM_CTRL) begin
        mem_ctrl_reg <= wbyte & MASK_MEM_CTRL;
      end
      if (PADDR == OFF_E_DIR) begin
        e_dir_reg <= wbyte;
      end
    end
  end

  // Open-drain class per pin, from the bit that owns each pin
  always_comb begin
    c_od_class = '0;
    d_od_class = '0;
    if (od_first_reg[BIT_SSP1_OD]) begin
      c_od_class = c_od_class | PORT_WIDTH'(C_SSP1_PINS);
    end
    if (od_third_reg[BIT_U1_OD]) begin
      c_od_class = c_od_class | PORT_WIDTH'(C_U1_PINS);
    end
    // Compare unit two only counts while it is mapped onto C1
    c_od_class[PIN_CCP2] = od_first_reg[BIT_CCP2_OD] & COMPARE_TWO_PIN_SELECT;
    c_od_class[PIN_CCP1] = od_first_reg[BIT_CCP1_OD];
    if (od_first_reg[BIT_SSP2_OD]) begin
      d_od_class = PORT_WIDTH'(D_SSP2_PINS);
    end
  end

  // Per-pin drive for both ports
  genvar gi;
  generate
    for (gi = 0; gi < PORT_WIDTH; gi++) begin : g_pin
      logic c_data_en;
      logic c_drive;
      logic c_data;
      logic c_func;
      logic d_drive;
      logic d_data;
      logic d_func;

      // C1 ignores compare unit two data when it is mapped elsewhere; its direction override still applies
      assign c_data_en = C_PERIPH_DATA_EN[gi] & ((gi != PIN_CCP2) | COMPARE_TWO_PIN_SELECT);
      assign c_func = c_data_en | C_PERIPH_DIR_OVR[gi];
      // Forced direction wins over the software bit
      assign c_drive = C_PERIPH_DIR_OVR[gi] ? C_PERIPH_DRIVE[gi] : ~c_dir_reg[gi];
      assign c_data = c_data_en ? C_PERIPH_DATA[gi] : c_latch_reg[gi];

      // Port D ordering: external bus, then slave port, then peripherals
      assign d_func = D_PERIPH_DATA_EN[gi] | D_PERIPH_DIR_OVR[gi];
      always_comb begin
        if (ext_bus_on) begin
          d_drive = EXT_BUS_DRIVE;
          d_data = EXT_BUS_DATA[gi];
        end else if (psp_on) begin
          d_drive = PSP_DRIVE;
          d_data = PSP_DATA[gi];
        end else begin
          d_drive = D_PERIPH_DIR_OVR[gi] ? D_PERIPH_DRIVE[gi] : ~d_dir_reg[gi];
          d_data = D_PERIPH_DATA_EN[gi] ? D_PERIPH_DATA[gi] : d_latch_reg[gi];
        end
      end

      // Pad enable; open-drain only pulls low, shutdown floats the pin
      always_comb begin
        c_out_next[gi] = c_data;
        c_oe_next[gi] = c_drive & ~C_PWM_FLOAT[gi];
        if (c_func && c_od_class[gi]) begin
          c_out_next[gi] = 1'b0;
          c_oe_next[gi] = c_drive & ~c_data & ~C_PWM_FLOAT[gi];
        end
        d_out_next[gi] = d_data;
        d_oe_next[gi] = d_drive;
        if (d_func && d_od_class[gi] && !ext_bus_on && !psp_on) begin
          d_out_next[gi] = 1'b0;
          d_oe_next[gi] = d_drive & ~d_data;
        end
      end
    end
  endgenerate

  // Pad outputs; reset leaves every enable low
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      c_out_reg <= '0;
      c_oe_reg <= '0;
      d_out_reg <= '0;
      d_oe_reg <= '0;
    end else begin
      c_out_reg <= c_out_next;
      c_oe_reg <= c_oe_next;
      d_out_reg <= d_out_next;
      d_oe_reg <= d_oe_next;
    end
  end

  // Pull-ups: global disable bit, and off on any pin that drives
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      d_pull_reg <= '0;
    end else if (pad_cfg_reg[BIT_PULLUP_DIS]) begin
      d_pull_reg <= '0;
    end else begin
      d_pull_reg <= ~d_oe_next;
    end
  end

  // Mode indications for the pads and neighbouring blocks
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bus_own_reg <= 1'b0;
      psp_reg <= 1'b0;
      sec_clk_reg <= 1'b0;
    end else begin
      bus_own_reg <= ext_bus_on;
      psp_reg <= psp_on;
      // C0 feeds the digital clock path only with the oscillator off
      sec_clk_reg <= c_sync_reg[PIN_SEC_CLK] & ~SEC_OSC_ENABLE;
    end
  end

  // Read mux; direction reads show the stored value, never the override
  always_comb begin
    rdata_next = '0;
    err_next = 1'b0;
    unique case (PADDR)
      OFF_C_PIN: rdata_next[PORT_WIDTH-1:0] = c_sync_reg;
      OFF_C_LATCH: rdata_next[PORT_WIDTH-1:0] = c_latch_reg;
      OFF_C_DIR: rdata_next[PORT_WIDTH-1:0] = c_dir_reg;
      OFF_D_PIN: rdata_next[PORT_WIDTH-1:0] = d_sync_reg;
      OFF_D_LATCH: rdata_next[PORT_WIDTH-1:0] = d_latch_reg;
      OFF_D_DIR: rdata_next[PORT_WIDTH-1:0] = d_dir_reg;
      OFF_OD_FIRST: rdata_next[7:0] = od_first_reg;
      OFF_OD_THIRD: rdata_next[7:0] = od_third_reg;
      OFF_PAD_CFG: rdata_next[7:0] = pad_cfg_reg;
      OFF_MEM_CTRL: rdata_next[7:0] = mem_ctrl_reg;
      OFF_E_DIR: rdata_next[7:0] = e_dir_reg;
      // Unmapped address answers with an error and zero data
      default: err_next = 1'b1;
    endcase
  end

  // Bus answer: ready for exactly the first access cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ready_reg <= 1'b0;
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      ready_reg <= setup_phase;
      if (setup_phase) begin
        rdata_reg <= PWRITE ? 32'h0000_0000 : rdata_next;
        err_reg <= err_next;
      end else begin
        rdata_reg <= 32'h0000_0000;
        err_reg <= 1'b0;
      end
    end
  end

  // Output wiring, all straight from flops
  assign PREADY = ready_reg;
  assign PRDATA = rdata_reg;
  assign PSLVERR = err_reg;
  assign C_PAD_OUT = c_out_reg;
  assign C_PAD_OE = c_oe_reg;
  assign D_PAD_OUT = d_out_reg;
  assign D_PAD_OE = d_oe_reg;
  assign D_PULLUP_EN = d_pull_reg;
  assign D_TTL_INPUT = psp_reg;
  assign C_PIN_SYNC = c_sync_reg;
  assign D_PIN_SYNC = d_sync_reg;
  assign EXT_BUS_OWNS_D = bus_own_reg;
  assign PSP_ACTIVE = psp_reg;
  assign SEC_CLOCK_IN = sec_clk_reg;

endmodule // gpio_cd

// ==== bench/pad_board.sv ====
`timescale 1ns/1ps
module pad_board (
  // Clock
  input wire logic clk,
  // Pad drive from the port
  input wire logic [7:0] oe,
  input wire logic [7:0] dout,
  input wire logic [7:0] pull_en,
  // Board drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved pin level
  output logic [7:0] pad
);
  // Undriven pins wander, so a stale level never looks valid
  logic [7:0] float_reg = 8'h55;
  always @(posedge clk) float_reg <= ~float_reg;
  // Port wins over board; pull-up only on an otherwise idle pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad[i] = oe[i] ? dout[i] : ext_en[i] ? ext_val[i] : pull_en[i] ? 1'b1 : float_reg[i];
    end
  end
endmodule // pad_board

// ==== bench/gpio_cd_asserts.sv ====
`timescale 1ns/1ps
module gpio_cd_asserts
  import gpio_cd_pkg::*;
#(
  parameter int PORT_WIDTH = 8 // Pins per port
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  // Pads
  input wire logic [PORT_WIDTH-1:0] C_PAD_IN,
  input wire logic [PORT_WIDTH-1:0] C_PAD_OE,
  input wire logic [PORT_WIDTH-1:0] C_PWM_FLOAT,
  input wire logic [PORT_WIDTH-1:0] C_PIN_SYNC,
  input wire logic [PORT_WIDTH-1:0] D_PAD_OE,
  input wire logic [PORT_WIDTH-1:0] D_PULLUP_EN,
  // Modes
  input wire logic EXT_BUS_DRIVE,
  input wire logic EXT_BUS_OWNS_D,
  input wire logic PSP_ACTIVE,
  input wire logic MCU_MODE,
  input wire logic SEC_OSC_ENABLE,
  input wire logic SEC_CLOCK_IN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Fixed one-cycle answer
  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  // Shutdown float beats every drive source
  property p_float; $past(NRST) |-> (C_PAD_OE & $past(C_PWM_FLOAT)) == '0; endproperty
  a_float: assert property (p_float) else $error("pin driven during float");
  // Output pins never keep a pull-up
  property p_pull_out; (D_PULLUP_EN & D_PAD_OE) == '0; endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull-up on output pin");
  // Clock input blocked while oscillator runs
  property p_sec; SEC_OSC_ENABLE |=> !SEC_CLOCK_IN; endproperty
  a_sec: assert property (p_sec) else $error("clock input with oscillator on");
  // Two stages, so the levels lag two edges
  property p_sync; $past(NRST) && $past(NRST, 2) |-> C_PIN_SYNC == $past(C_PAD_IN, 2); endproperty
  a_sync: assert property (p_sync) else $error("synchroniser depth wrong");
  // Bus direction overrides the port
  property p_bus; $past(NRST) && EXT_BUS_OWNS_D |-> D_PAD_OE == {PORT_WIDTH{$past(EXT_BUS_DRIVE)}}; endproperty
  a_bus: assert property (p_bus) else $error("bus does not own port d");
  // Slave port needs microcontroller mode
  property p_psp; !MCU_MODE |=> !PSP_ACTIVE; endproperty
  a_psp: assert property (p_psp) else $error("slave port outside mode");
  // Disable bit clears every pull-up
  property p_pull_dis;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFF_PAD_CFG && PSTRB[0] && PWDATA[7] |-> ##2 D_PULLUP_EN == '0;
  endproperty
  a_pull_dis: assert property (p_pull_dis) else $error("pull-ups stay on");
endmodule // gpio_cd_asserts
bind gpio_cd gpio_cd_asserts #(.PORT_WIDTH(PORT_WIDTH)) gpio_cd_asserts_i (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
  .C_PAD_IN(C_PAD_IN), .C_PAD_OE(C_PAD_OE), .C_PWM_FLOAT(C_PWM_FLOAT), .C_PIN_SYNC(C_PIN_SYNC),
  .D_PAD_OE(D_PAD_OE), .D_PULLUP_EN(D_PULLUP_EN), .EXT_BUS_DRIVE(EXT_BUS_DRIVE), .EXT_BUS_OWNS_D(EXT_BUS_OWNS_D),
  .PSP_ACTIVE(PSP_ACTIVE), .MCU_MODE(MCU_MODE), .SEC_OSC_ENABLE(SEC_OSC_ENABLE), .SEC_CLOCK_IN(SEC_CLOCK_IN));

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import gpio_cd_pkg::*;
  // Clock, reset, APB
  logic CLK = 1'b0, NRST = 1'b0, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0] PSTRB;
  // Pads, peripherals, board
  logic [7:0] C_PAD_IN, C_PAD_OUT, C_PAD_OE, D_PAD_IN, D_PAD_OUT, D_PAD_OE, D_PULLUP_EN;
  logic [7:0] C_PERIPH_DATA_EN, C_PERIPH_DATA, C_PERIPH_DIR_OVR, C_PERIPH_DRIVE, C_PWM_FLOAT;
  logic [7:0] D_PERIPH_DATA_EN, D_PERIPH_DATA, D_PERIPH_DIR_OVR, D_PERIPH_DRIVE;
  logic [7:0] EXT_BUS_DATA, PSP_DATA, c_ext_en, c_ext_val, d_ext_en, d_ext_val;
  logic EXT_BUS_DRIVE, EXT_BUS_OWNS_D, PSP_DRIVE, PSP_ACTIVE, MCU_MODE, D_TTL_INPUT;
  logic COMPARE_TWO_PIN_SELECT, SEC_OSC_ENABLE, SEC_CLOCK_IN;
  // Port D synchronised levels, watched directly
  logic [7:0] D_PIN_SYNC;
  int fail_count = 0, compares = 0;
  // 20 MHz
  always #25 CLK = ~CLK;
  gpio_cd gpio_cd_i (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .C_PAD_IN(C_PAD_IN),
    .C_PAD_OUT(C_PAD_OUT), .C_PAD_OE(C_PAD_OE), .D_PAD_IN(D_PAD_IN), .D_PAD_OUT(D_PAD_OUT), .D_PAD_OE(D_PAD_OE),
    .D_PULLUP_EN(D_PULLUP_EN), .D_TTL_INPUT(D_TTL_INPUT), .C_PIN_SYNC(), .D_PIN_SYNC(D_PIN_SYNC),
    .C_PERIPH_DATA_EN(C_PERIPH_DATA_EN), .C_PERIPH_DATA(C_PERIPH_DATA), .C_PERIPH_DIR_OVR(C_PERIPH_DIR_OVR),
    .C_PERIPH_DRIVE(C_PERIPH_DRIVE), .C_PWM_FLOAT(C_PWM_FLOAT), .D_PERIPH_DATA_EN(D_PERIPH_DATA_EN),
    .D_PERIPH_DATA(D_PERIPH_DATA), .D_PERIPH_DIR_OVR(D_PERIPH_DIR_OVR), .D_PERIPH_DRIVE(D_PERIPH_DRIVE),
    .EXT_BUS_DATA(EXT_BUS_DATA), .EXT_BUS_DRIVE(EXT_BUS_DRIVE), .EXT_BUS_OWNS_D(EXT_BUS_OWNS_D),
    .PSP_DATA(PSP_DATA), .PSP_DRIVE(PSP_DRIVE), .PSP_ACTIVE(PSP_ACTIVE), .MCU_MODE(MCU_MODE),
    .COMPARE_TWO_PIN_SELECT(COMPARE_TWO_PIN_SELECT), .SEC_OSC_ENABLE(SEC_OSC_ENABLE), .SEC_CLOCK_IN(SEC_CLOCK_IN));
  // Port C has no pull-ups
  pad_board c_board_i (.clk(CLK), .oe(C_PAD_OE), .dout(C_PAD_OUT), .pull_en(8'h00), .ext_en(c_ext_en),
    .ext_val(c_ext_val), .pad(C_PAD_IN));
  pad_board d_board_i (.clk(CLK), .oe(D_PAD_OE), .dout(D_PAD_OUT), .pull_en(D_PULLUP_EN), .ext_en(d_ext_en),
    .ext_val(d_ext_val), .pad(D_PAD_IN));
  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  // One APB transfer; idle edge first so strobes never change twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [7:0] q);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    q = PRDATA[7:0];
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    apb(1'b0, a, 8'h00, 4'hf, q);
    chk("read data", e, q);
  endtask
  // Pads are levels; three edges cover the registered path
  task automatic tick;
    repeat (3) @(posedge CLK);
  endtask
  task automatic cpins(input logic [7:0] eo, input logic [7:0] ed);
    tick;
    chk("c oe", eo, C_PAD_OE);
    chk("c out", ed, C_PAD_OUT);
  endtask
  task automatic dpins(input logic [7:0] eo, input logic [7:0] ed);
    tick;
    chk("d oe", eo, D_PAD_OE);
    chk("d out", ed, D_PAD_OUT);
  endtask
  // Reset state, masks, refusals
  task automatic t_reset;
    logic [11:0] ra [9];
    logic [7:0] rv [9];
    logic [7:0] q;
    ra = '{OFF_C_LATCH, OFF_C_DIR, OFF_D_LATCH, OFF_D_DIR, OFF_OD_FIRST, OFF_OD_THIRD, OFF_PAD_CFG, OFF_MEM_CTRL,
           OFF_E_DIR};
    rv = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h80, 8'h00, 8'hff};
    tick;
    chk("c oe", 8'h00, C_PAD_OE);
    chk("d oe", 8'h00, D_PAD_OE);
    chk("d pullup", 8'h00, D_PULLUP_EN);
    chk("bus owns", 8'h01, {7'h00, EXT_BUS_OWNS_D});
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    wr(OFF_OD_FIRST, 8'hff);
    rd(OFF_OD_FIRST, 8'he1);
    wr(OFF_OD_THIRD, 8'hff);
    rd(OFF_OD_THIRD, 8'hc1);
    wr(OFF_PAD_CFG, 8'hff);
    rd(OFF_PAD_CFG, 8'he6);
    apb(1'b0, 12'h02c, 8'h00, 4'hf, q);
    chk("unmapped read", 8'h00, q);
    chk("unmapped error", 8'h01, {7'h00, err});
    apb(1'b1, OFF_C_LATCH, 8'hff, 4'h0, q);
    rd(OFF_C_LATCH, 8'h00);
    $display("test reset done");
  endtask
  // Port C: direction, overrides, open-drain, float, pin select, clock input
  task automatic t_cport;
    wr(OFF_OD_FIRST, 8'h00);
    wr(OFF_OD_THIRD, 8'h00);
    wr(OFF_C_DIR, 8'hfe);
    wr(OFF_C_LATCH, 8'h01);
    c_ext_en <= 8'hfe;
    c_ext_val <= 8'ha0;
    cpins(8'h01, 8'h01);
    rd(OFF_C_PIN, 8'ha1);
    C_PERIPH_DIR_OVR <= 8'h04;
    C_PERIPH_DRIVE <= 8'h04;
    C_PERIPH_DATA_EN <= 8'h04;
    C_PERIPH_DATA <= 8'h04;
    cpins(8'h05, 8'h05);
    rd(OFF_C_DIR, 8'hfe);
    wr(OFF_OD_FIRST, 8'h20);
    cpins(8'h01, 8'h01);
    C_PERIPH_DATA <= 8'h00;
    cpins(8'h05, 8'h01);
    C_PWM_FLOAT <= 8'h04;
    cpins(8'h01, 8'h01);
    C_PWM_FLOAT <= 8'h00;
    C_PERIPH_DIR_OVR <= 8'h06;
    C_PERIPH_DRIVE <= 8'h06;
    C_PERIPH_DATA_EN <= 8'h06;
    C_PERIPH_DATA <= 8'h02;
    wr(OFF_OD_FIRST, 8'h40);
    cpins(8'h05, 8'h01);
    COMPARE_TWO_PIN_SELECT <= 1'b0;
    cpins(8'h07, 8'h01);
    {C_PERIPH_DATA_EN, C_PERIPH_DIR_OVR} <= 16'h0000;
    SEC_OSC_ENABLE <= 1'b0;
    tick;
    chk("sec clock", 8'h01, {7'h00, SEC_CLOCK_IN});
    SEC_OSC_ENABLE <= 1'b1;
    tick;
    chk("sec clock", 8'h00, {7'h00, SEC_CLOCK_IN});
    $display("test port c done");
  endtask
  // Port D: bus, pull-ups, serial open-drain, slave port
  task automatic t_dport;
    EXT_BUS_DATA <= 8'h5a;
    EXT_BUS_DRIVE <= 1'b1;
    dpins(8'hff, 8'h5a);
    EXT_BUS_DRIVE <= 1'b0;
    wr(OFF_MEM_CTRL, 8'h80);
    wr(OFF_D_DIR, 8'hf0);
    wr(OFF_PAD_CFG, 8'h00);
    dpins(8'h0f, 8'h00);
    chk("bus owns", 8'h00, {7'h00, EXT_BUS_OWNS_D});
    chk("d pullup", 8'hf0, D_PULLUP_EN);
    wr(OFF_PAD_CFG, 8'h80);
    tick;
    chk("d pullup", 8'h00, D_PULLUP_EN);
    {D_PERIPH_DATA_EN, D_PERIPH_DIR_OVR, D_PERIPH_DRIVE, D_PERIPH_DATA} <= 32'h10101010;
    dpins(8'h1f, 8'h10);
    wr(OFF_OD_FIRST, 8'h01);
    dpins(8'h0f, 8'h00);
    {D_PERIPH_DATA_EN, D_PERIPH_DIR_OVR} <= 16'h0000;
    MCU_MODE <= 1'b1;
    PSP_DATA <= 8'h3c;
    PSP_DRIVE <= 1'b1;
    dpins(8'hff, 8'h3c);
    chk("ttl input", 8'h01, {7'h00, D_TTL_INPUT});
    // Slave port drive comes back through the port D synchroniser
    rd(OFF_D_PIN, 8'h3c);
    chk("d pin sync", 8'h3c, D_PIN_SYNC);
    wr(OFF_E_DIR, 8'hef);
    tick;
    chk("slave port", 8'h00, {7'h00, PSP_ACTIVE});
    wr(OFF_E_DIR, 8'hff);
    MCU_MODE <= 1'b0;
    dpins(8'h0f, 8'h00);
    chk("slave port", 8'h00, {7'h00, PSP_ACTIVE});
    $display("test port d done");
  endtask
  // Verdict and end of run
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
    {C_PERIPH_DATA_EN, C_PERIPH_DATA, C_PERIPH_DIR_OVR, C_PERIPH_DRIVE, C_PWM_FLOAT} = '0;
    {D_PERIPH_DATA_EN, D_PERIPH_DATA, D_PERIPH_DIR_OVR, D_PERIPH_DRIVE} = '0;
    {EXT_BUS_DATA, EXT_BUS_DRIVE, PSP_DATA, PSP_DRIVE, MCU_MODE, c_ext_en, c_ext_val, d_ext_en, d_ext_val} = '0;
    {COMPARE_TWO_PIN_SELECT, SEC_OSC_ENABLE} = 2'b11;
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    t_reset;
    t_cport;
    t_dport;
    results;
  end
  // Run takes under two hundred cycles; over fifteen times that means a hang
  initial begin
    repeat (3000) @(posedge CLK);
    fail_count++;
    results;
  end
endmodule // tb_top
